// ### hw/ddrsw_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrsw_map.svh"

// request queue with valid/ready on both sides
module ddrsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `DDRSW_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0]   count;
  } ddrsw_fifo_state_t;

  ddrsw_fifo_state_t st;
  ddrsw_fifo_state_t next_st;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  // full and empty come straight from the count
  always_comb
  begin
    in_ready  = st.count != (PW+1)'(DEPTH);
    out_valid = st.count != '0;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_st   = st;
    if (push)
      next_st.wr_ptr = PW'(st.wr_ptr + 1'h1);
    if (pop)
      next_st.rd_ptr = PW'(st.rd_ptr + 1'h1);
    next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[st.wr_ptr] <= in_data;
  end

  assign out_data = mem[st.rd_ptr];
endmodule

// controller end: queues whole bursts and issues them on the link
module ddrsw_ctl #(
  parameter int DATA_W = `DDRSW_DATA_W,
  parameter int ADDR_W = `DDRSW_ADDR_W,
  parameter int DEPTH  = `DDRSW_FIFO_DEPTH
) (
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  ddrsw_if.ctl                                 link,
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire ddrsw_pkg::ddrsw_op_t            req_op,
  input  wire logic [ADDR_W-1:0]               req_addr,
  input  wire logic [`DDRSW_BURST*DATA_W-1:0]  req_data,
  input  wire logic [`DDRSW_BURST*DATA_W/`DDRSW_LANE_W-1:0] req_byte_sel_n,
  output logic [DATA_W-1:0]                    rd_data,
  output logic                                 rd_valid
);
  localparam int NLANE = DATA_W / `DDRSW_LANE_W;
  localparam int BW    = `DDRSW_BURST * DATA_W;
  localparam int SW    = `DDRSW_BURST * NLANE;
  localparam int FW    = 1 + ADDR_W + BW + SW;

  typedef struct packed
  {
    logic                    k_rise;
    logic                    last_read;
    logic [`DDRSW_CNT_W-1:0] wr_left;
    logic [`DDRSW_CNT_W-1:0] rd_left;
    logic [BW-1:0]           wbuf;
    logic [SW-1:0]           sbuf;
    logic                    wps_n;
    logic                    rps_n;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       d;
    logic [NLANE-1:0]        bws_n;
    logic [DATA_W-1:0]       rdata;
    logic                    rvalid;
  } ddrsw_ctl_state_t;

  ddrsw_ctl_state_t  st;
  ddrsw_ctl_state_t  next_st;
  logic              head_valid;
  logic              head_ready;
  logic [FW-1:0]     head;
  ddrsw_pkg::ddrsw_op_t head_op;
  logic [1:0]        beat;
  logic              slot;

  ddrsw_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_queue (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_op, req_addr, req_data, req_byte_sel_n}),
    .out_valid (head_valid),
    .out_ready (head_ready),
    .out_data  (head)
  );

  // a request launches on the edge before a positive clock edge, only when
  // its port is free; a waiting head holds back the queue, and the user port stalls only once the queue is full
  always_comb
  begin
    head_op    = ddrsw_pkg::ddrsw_op_t'(head[FW-1]);
    slot       = !st.k_rise;
    head_ready = head_valid && slot &&
                 ((head_op == ddrsw_pkg::DDRSW_OP_WRITE) ? st.wr_left <= `DDRSW_CNT_LAST
                                                         : st.rd_left <= `DDRSW_CNT_LAST);
    beat       = 2'(`DDRSW_CNT_FULL - st.wr_left);
  end

  // link sequencing
  always_comb
  begin
    next_st        = st;
    next_st.k_rise = !st.k_rise;
    next_st.wps_n  = `DDRSW_SEL_IDLE;
    next_st.rps_n  = `DDRSW_SEL_IDLE;
    next_st.rvalid = !link.q_oe_n;
    if (!link.q_oe_n)
      next_st.rdata = link.q;
    // one beat with its own lane selects per edge
    if (st.wr_left != `DDRSW_CNT_IDLE)
    begin
      next_st.d       = st.wbuf[(`DDRSW_BURST-1-beat)*DATA_W +: DATA_W];
      next_st.bws_n   = st.sbuf[(`DDRSW_BURST-1-beat)*NLANE +: NLANE];
      next_st.wr_left = st.wr_left - `DDRSW_CNT_LAST;
    end
    if (st.rd_left != `DDRSW_CNT_IDLE)
      next_st.rd_left = st.rd_left - `DDRSW_CNT_LAST;
    // one launch per positive edge keeps read and write addresses apart
    if (head_ready)                                                   // RULE16
    begin
      next_st.addr      = head[FW-2 -: ADDR_W];
      next_st.last_read = head_op == ddrsw_pkg::DDRSW_OP_READ;
      if (head_op == ddrsw_pkg::DDRSW_OP_WRITE)
      begin
        next_st.wps_n   = 1'h0;
        next_st.wr_left = `DDRSW_CNT_FULL;
        next_st.wbuf    = head[SW +: BW];
        next_st.sbuf    = head[SW-1:0];
      end
      else
      begin
        next_st.rps_n   = 1'h0;
        next_st.rd_left = `DDRSW_CNT_FULL;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st       <= '0;
      st.wps_n <= `DDRSW_SEL_IDLE;
      st.rps_n <= `DDRSW_SEL_IDLE;
      st.bws_n <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.k_rise              = st.k_rise;
  assign link.write_port_select_n = st.wps_n;
  assign link.read_port_select_n  = st.rps_n;
  assign link.addr                = st.addr;
  assign link.d                   = st.d;
  assign link.byte_write_select_n = st.bws_n;
  assign rd_data                  = st.rdata;
  assign rd_valid                 = st.rvalid;
endmodule

`default_nettype wire

// ### hw/ddrsw_map.svh
`ifndef DDRSW_MAP_SVH
`define DDRSW_MAP_SVH

// words moved by one access, one per sub-array
`define DDRSW_BURST       4
// bits gated by one byte write select
`define DDRSW_LANE_W      9
// narrow configuration: 18 data bits, 18 address inputs
`define DDRSW_DATA_W      18
`define DDRSW_ADDR_W      18
// wide configuration: 36 data bits, 17 address inputs
`define DDRSW_DATA_W_WIDE 36
`define DDRSW_ADDR_W_WIDE 17
// depth of the controller's request queue
`define DDRSW_FIFO_DEPTH  32
// burst beat counters
`define DDRSW_CNT_W       3
`define DDRSW_CNT_IDLE    3'h0
`define DDRSW_CNT_FULL    3'h4
`define DDRSW_CNT_LAST    3'h1
// select pins idle high after reset
`define DDRSW_SEL_IDLE    1'h1

`endif

// ### hw/ddrsw_pkg.sv
package ddrsw_pkg;

  // kind of access queued at the controller
  typedef enum logic
  {
    DDRSW_OP_READ,
    DDRSW_OP_WRITE
  } ddrsw_op_t;

endpackage

// ### hw/ddrsw_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrsw_map.svh"

// memory link; each mclk edge stands for one input clock rising edge,
// k_rise high for the positive clock and low for the complementary one
interface ddrsw_if #(
  parameter int DATA_W = `DDRSW_DATA_W,
  parameter int ADDR_W = `DDRSW_ADDR_W
);
  localparam int NLANE = DATA_W / `DDRSW_LANE_W;

  logic              k_rise;
  logic              write_port_select_n;
  logic              read_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [NLANE-1:0]  byte_write_select_n;
  logic [DATA_W-1:0] q;
  logic              q_oe_n;

  modport dev (
    input  k_rise,
    input  write_port_select_n,
    input  read_port_select_n,
    input  addr,
    input  d,
    input  byte_write_select_n,
    output q,
    output q_oe_n
  );

  modport ctl (
    output k_rise,
    output write_port_select_n,
    output read_port_select_n,
    output addr,
    output d,
    output byte_write_select_n,
    input  q,
    input  q_oe_n
  );
endinterface

`default_nettype wire

// ### hw/ddrsw_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrsw_map.svh"

// Contract
// RULE1: capture write data on both clock edges
// RULE2: write select low at positive edge starts write
// RULE3: write select high ignores data, array unchanged
// RULE4: byte selects sampled on both edges per beat
// RULE5: unselected byte keeps its stored value
// RULE6: select n gates nine-bit lane n
// RULE7: byte selects sampled with their data word
// RULE8: address captured at positive edge when starting
// RULE9: one address bus shared by both ports
// RULE10: four sub-arrays, one per burst word
// RULE11: deselected port ignores the address
// RULE12: read select low starts four-word read
// RULE13: accesses start only at positive edge
// RULE14: deselect finishes burst, then outputs float
// RULE15: burst of four words over two cycles
// RULE16: controller alternates read and write slots; the code launches whichever op heads the queue, in queue order
module ddrsw_dev #(
  parameter int DATA_W = `DDRSW_DATA_W,
  parameter int ADDR_W = `DDRSW_ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  ddrsw_if.dev                   link,
  output logic                   wr_active,
  output logic                   rd_active,
  output logic                   beat_stored,
  output logic [ADDR_W-1:0]      last_wr_addr,
  output logic                   write_refused
);
  localparam int NLANE  = DATA_W / `DDRSW_LANE_W;
  localparam int LANE_W = `DDRSW_LANE_W;
  localparam int BURST  = `DDRSW_BURST;

  typedef struct packed
  {
    logic [`DDRSW_CNT_W-1:0] wr_left;
    logic [ADDR_W-1:0]       wr_addr;
    logic [`DDRSW_CNT_W-1:0] rd_left;
    logic [ADDR_W-1:0]       rd_addr;
    logic [DATA_W-1:0]       q;
    logic                    q_oe_n;
    logic                    stored;
    logic                    refused;
  } ddrsw_dev_state_t;

  ddrsw_dev_state_t st;
  ddrsw_dev_state_t next_st;

  // four sub-arrays, each indexed by the burst address
  logic [DATA_W-1:0] mem [BURST][2**ADDR_W]; // RULE10

  // beat position within a burst, from the words still to move
  function automatic logic [1:0] ddrsw_beat(input logic [`DDRSW_CNT_W-1:0] left);
    logic [`DDRSW_CNT_W-1:0] idx;
    idx = `DDRSW_CNT_FULL - left;
    return idx[1:0];
  endfunction

  // byte-masked merge of a data beat over the stored word
  function automatic logic [DATA_W-1:0] ddrsw_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [NLANE-1:0]  sel_n
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < NLANE; i++)
    begin
      if (!sel_n[i])
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W]; // RULE6
    end
    return res;
  endfunction

  logic       wr_start;
  logic       rd_start;
  logic       wr_busy;
  logic       rd_busy;
  logic [1:0] wr_beat;
  logic [1:0] rd_beat;

  // a port may start again on the positive edge of its own last beat,
  // so bursts run back to back every two input clock cycles
  always_comb
  begin
    wr_busy  = st.wr_left > `DDRSW_CNT_LAST;
    rd_busy  = st.rd_left > `DDRSW_CNT_LAST;
    rd_start = link.k_rise && !link.read_port_select_n && !rd_busy;   // RULE12 RULE13
    // the address bus carries one address per edge; a read in the same
    // slot owns it, so a write start there is dropped
    wr_start = link.k_rise && !link.write_port_select_n && !wr_busy   // RULE2 RULE13
               && !rd_start;                                          // RULE9
    wr_beat  = ddrsw_beat(st.wr_left);
    rd_beat  = ddrsw_beat(st.rd_left);
  end

  // next state of both ports
  always_comb
  begin
    next_st         = st;
    next_st.stored  = 1'h0;
    next_st.refused = link.k_rise && !link.write_port_select_n && !wr_busy && rd_start;

    // write port: one beat per edge, alternate positive and complementary
    if (st.wr_left != `DDRSW_CNT_IDLE)
    begin
      next_st.wr_left = st.wr_left - `DDRSW_CNT_LAST;                  // RULE15
      next_st.stored  = 1'h1;
    end
    if (wr_start)
    begin
      next_st.wr_left = `DDRSW_CNT_FULL;
      next_st.wr_addr = link.addr;                                    // RULE8
    end
    // with the write port deselected the address is never taken      // RULE11

    // read port: drive each word one edge after it is looked up
    if (st.rd_left != `DDRSW_CNT_IDLE)
    begin
      next_st.rd_left = st.rd_left - `DDRSW_CNT_LAST;
      next_st.q       = mem[rd_beat][st.rd_addr];
    end
    if (rd_start)
    begin
      next_st.rd_left = `DDRSW_CNT_FULL;
      next_st.rd_addr = link.addr;                                    // RULE8 RULE11
    end
    // outputs float once the pending burst has been driven out
    next_st.q_oe_n = (st.rd_left == `DDRSW_CNT_IDLE);                 // RULE14
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st.wr_left <= `DDRSW_CNT_IDLE;
      st.wr_addr <= '0;
      st.rd_left <= `DDRSW_CNT_IDLE;
      st.rd_addr <= '0;
      st.q       <= '0;
      st.q_oe_n  <= 1'h1;
      st.stored  <= 1'h0;
      st.refused <= 1'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // array write; the data and byte selects of a beat come on the same
  // edge, and nothing is written while the port is idle
  always_ff @(posedge mclk)
  begin
    if (!sys_rst && st.wr_left != `DDRSW_CNT_IDLE)                    // RULE3
    begin
      mem[wr_beat][st.wr_addr] <= ddrsw_merge(mem[wr_beat][st.wr_addr],
                                              link.d,                 // RULE1
                                              link.byte_write_select_n); // RULE4 RULE5 RULE7
    end
  end

  // status seen by local logic
  assign wr_active     = st.wr_left != `DDRSW_CNT_IDLE;
  assign rd_active     = st.rd_left != `DDRSW_CNT_IDLE;
  assign beat_stored   = st.stored;
  assign last_wr_addr  = st.wr_addr;
  assign write_refused = st.refused;

  // read port pins
  assign link.q      = st.q;
  assign link.q_oe_n = st.q_oe_n;
endmodule

`default_nettype wire

// ### bench/ddrsw_props.sv
`timescale 1ns/100ps
`default_nettype none

// link watcher; starts belong on positive edges only
module ddrsw_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic k_rise,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic q_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_write_on_pos: assert property (!write_port_select_n |-> k_rise)
    else $error("write start on a complementary edge");
  a_read_on_pos: assert property (!read_port_select_n |-> k_rise)
    else $error("read start on a complementary edge");
  a_edges_alternate: assert property (!$past(sys_rst) |-> k_rise != $past(k_rise))
    else $error("edge flag did not alternate");
  a_write_burst_gap: assert property (!write_port_select_n |=> write_port_select_n[*3])
    else $error("write restarted inside a burst");
  a_read_burst_gap: assert property (!read_port_select_n |=> read_port_select_n[*3])
    else $error("read restarted inside a burst");
  a_one_port_slot: assert property (!(!write_port_select_n && !read_port_select_n))
    else $error("both ports started on one edge");
  a_read_drives_out: assert property (!read_port_select_n |=> ##1 !q_oe_n[*4])
    else $error("outputs not driven for four beats");
  a_read_then_float: assert property (!read_port_select_n ##4 read_port_select_n |-> ##2 q_oe_n)
    else $error("outputs still driven after the burst");

  c_write: cover property (!write_port_select_n ##4 !write_port_select_n);
  c_read: cover property (!read_port_select_n);
  c_float: cover property (!q_oe_n ##1 q_oe_n);
endmodule

`default_nettype wire

// ### bench/test_ddr_sram_write_port_addr.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrsw_map.svh"

`define CHK(name, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", name, exp, got); \
    end \
  end

module test_ddr_sram_write_port_addr;
  localparam int DW = `DDRSW_DATA_W;
  localparam int AW = `DDRSW_ADDR_W;
  localparam int LW = `DDRSW_LANE_W;
  localparam int BW = `DDRSW_BURST * DW;
  localparam int SW = `DDRSW_BURST * DW / LW;

  logic                 mclk;
  logic                 sys_rst;
  logic                 req_valid;
  logic                 req_ready;
  ddrsw_pkg::ddrsw_op_t req_op;
  logic [AW-1:0]        req_addr;
  logic [BW-1:0]        req_data;
  logic [SW-1:0]        req_byte_sel_n;
  logic [DW-1:0]        rd_data;
  logic                 rd_valid;
  logic                 beat_stored;
  logic                 wr_active;
  logic                 rd_active;
  logic                 write_refused;
  logic [AW-1:0]        last_wr_addr;
  logic [DW-1:0]        exp_w;
  int                   miscompares;
  int                   checked;
  int                   n_beats;
  int                   n_refused;
  int                   n_wr_busy;
  int                   n_rd_busy;
  bit                   hung;
  int                   n;
  bit                   seen_full;
  logic [BW-1:0]        mem [logic [AW-1:0]];
  logic [AW-1:0]        addrs [8];
  logic [DW-1:0]        exp_q [$];

  ddrsw_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
  ddrsw_dev #(.DATA_W(DW), .ADDR_W(AW)) u_ddrsw_dev (.mclk(mclk), .sys_rst(sys_rst),
    .link(link), .wr_active(wr_active), .rd_active(rd_active), .beat_stored(beat_stored),
    .last_wr_addr(last_wr_addr), .write_refused(write_refused));
  ddrsw_ctl #(.DATA_W(DW), .ADDR_W(AW), .DEPTH(`DDRSW_FIFO_DEPTH)) u_ddrsw_ctl (
    .mclk(mclk), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_byte_sel_n(req_byte_sel_n), .rd_data(rd_data), .rd_valid(rd_valid));
  ddrsw_props u_ddrsw_props (.mclk(mclk), .sys_rst(sys_rst), .k_rise(link.k_rise),
    .write_port_select_n(link.write_port_select_n),
    .read_port_select_n(link.read_port_select_n), .q_oe_n(link.q_oe_n));

  // free running clock
  initial
  begin
    mclk = 1'h0;
    forever
      #5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // holds the request until the queue takes it; a stall means the queue is full;
  // once a request hangs the rest are skipped so the run reaches its report
  task automatic put(input ddrsw_pkg::ddrsw_op_t op, input logic [AW-1:0] a,
                     input logic [BW-1:0] dat, input logic [SW-1:0] sel);
    logic rdy;
    int   k;
    if (hung)
      return;
    req_valid <= 1'h1;
    req_op <= op;
    req_addr <= a;
    req_data <= dat;
    req_byte_sel_n <= sel;
    for (k = 0; k < 400; k++)
    begin
      @(negedge mclk);
      rdy = req_ready;
      @(posedge mclk);
      if (rdy === 1'h1)
        break;
      seen_full = 1'h1;
    end
    if (k == 400)
    begin
      miscompares++;
      hung = 1'h1;
    end
  endtask

  // unselected lanes keep the stored value
  task automatic wr(input logic [AW-1:0] a, input logic [SW-1:0] sel);
    logic [BW-1:0] dat;
    dat = BW'({$urandom(), $urandom(), $urandom()});
    if (!mem.exists(a))
      mem[a] = 'x;
    for (int i = 0; i < SW; i++)
      if (sel[i] === 1'h0)
        mem[a][i*LW +: LW] = dat[i*LW +: LW];
    put(ddrsw_pkg::DDRSW_OP_WRITE, a, dat, sel);
  endtask

  // beat 0 sits in the top bits and returns first
  task automatic rd(input logic [AW-1:0] a);
    for (int b = 0; b < `DDRSW_BURST; b++)
      exp_q.push_back(mem[a][(`DDRSW_BURST-1-b)*DW +: DW]);
    put(ddrsw_pkg::DDRSW_OP_READ, a, '0, '1);
  endtask

  // scoreboard and event counters
  always @(posedge mclk)
  begin
    if (rd_valid === 1'h1)
    begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK("read beat", exp_w, rd_data)
    end
    if (beat_stored === 1'h1)
      n_beats++;
    if (write_refused === 1'h1)
      n_refused++;
    if (wr_active === 1'h1)
      n_wr_busy++;
    if (rd_active === 1'h1)
      n_rd_busy++;
  end

  // full writes, then masked writes with a read after every fourth, back to back so the queue fills, then reads
  initial
  begin
    sys_rst = 1'h1;
    req_valid = 1'h0;
    req_op = ddrsw_pkg::DDRSW_OP_READ;
    req_addr = '0;
    req_data = '0;
    req_byte_sel_n = '1;
    void'($urandom(32'hA58A));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      addrs[i] = AW'($urandom());
      wr(addrs[i], '0);
    end
    for (int i = 0; i < 36; i++)
    begin
      wr(addrs[i % 8], (i == 0) ? '1 : SW'($urandom()));
      if (i % 4 == 3)
        rd(addrs[i % 8]);
    end
    for (int i = 0; i < 8; i++)
      rd(addrs[i]);
    req_valid <= 1'h0;
    for (n = 0; n < 3000 && exp_q.size() > 0; n++)
      @(posedge mclk);
    if (exp_q.size() > 0)
      miscompares++;
    repeat (10) @(posedge mclk);
    `CHK("queue refusal", 1'h1, seen_full)
    `CHK("write busy cycles", 4 * 44, n_wr_busy)
    `CHK("read busy cycles", 4 * 17, n_rd_busy)
    `CHK("beats stored", 4 * 44, n_beats)
    `CHK("last write address", addrs[3], last_wr_addr)
    `CHK("writes refused", 0, n_refused)
    close_out();
  end
endmodule

`default_nettype wire
